// file: hw/sbs_pkg.sv
// Constants and types shared by the burst memory core and its helpers.
// Assumes one 100 MHz clock; no software-visible registers exist.
package sbs_pkg;

	// ---------------------------------------------------------------
	// Array geometry
	// ---------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int DEPTH = 32768;
	localparam int LANES = 4;
	localparam int BYTE_W = 8;
	localparam int LANE_W = 9;
	localparam int WORD_W = 36;
	localparam int DATA_W = 32;
	localparam int BURST_W = 2;

	// ---------------------------------------------------------------
	// Fixed values
	// ---------------------------------------------------------------
	localparam logic [BURST_W-1:0] BURST_INC = 2'h1;
	localparam logic [LANES-1:0] LANES_IDLE = 4'hf;
	localparam logic [LANES-1:0] LANES_NONE = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

	// Selection state: power-down deselect or active burst
	typedef enum logic [1:0] {
		MODE_DOWN = 2'b01,
		MODE_ACTIVE = 2'b10
	} sbs_mode_type;

endpackage

// file: hw/sbs_burst_ctr.sv
// Burst address generator: loads an external word address and steps
// its two low bits in linear wrapping order.
// Updates only while the clock enable is high; load and step need no gating by the caller.
module sbs_burst_ctr (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic load_i,
	input wire logic step_i,
	input wire logic [sbs_pkg::ADDR_W-1:0] load_addr_i,
	output logic [sbs_pkg::ADDR_W-1:0] cur_addr_o,
	output logic [sbs_pkg::ADDR_W-1:0] acc_addr_o
);
	import sbs_pkg::*;

	logic [ADDR_W-1:0] cur_q;
	logic [BURST_W-1:0] low_d;

	// Only the low bits move and wrap; the upper bits hold the burst in place
	assign low_d = cur_q[BURST_W-1:0] + BURST_INC;
	always_comb begin
		if (load_i) begin
			acc_addr_o = load_addr_i;
		end else if (step_i) begin
			acc_addr_o = {cur_q[ADDR_W-1:BURST_W], low_d};
		end else begin
			acc_addr_o = cur_q;
		end
	end

	// Current burst address
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			cur_q <= ADDR_RESET;
		end else if (clk_en_i) begin
			cur_q <= acc_addr_o;
		end
	end

	assign cur_addr_o = cur_q;
endmodule

// file: hw/sbs_word_mem.sv
// Word array with per-lane write enables and a registered read port.
// Assumes address and controls are stable from the caller's registers.
module sbs_word_mem (
	input wire logic ref_clk_i,
	input wire logic clk_en_i,
	input wire logic rd_en_i,
	input wire logic [sbs_pkg::ADDR_W-1:0] addr_i,
	input wire logic [sbs_pkg::LANES-1:0] lane_we_i,
	input wire logic [sbs_pkg::WORD_W-1:0] wdata_i,
	output logic [sbs_pkg::WORD_W-1:0] rdata_o
);
	import sbs_pkg::*;

	logic [WORD_W-1:0] mem [DEPTH];
	logic [WORD_W-1:0] rd_q;

	// Lane writes; unwritten lanes keep their contents
	always_ff @(posedge ref_clk_i) begin
		if (clk_en_i) begin
			for (int l = 0; l < LANES; l++) begin
				if (lane_we_i[l]) begin
					mem[addr_i][l*LANE_W +: LANE_W] <=
						wdata_i[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	// Read register; written lanes pass straight through to it
	always_ff @(posedge ref_clk_i) begin
		if (clk_en_i && rd_en_i) begin
			for (int l = 0; l < LANES; l++) begin
				rd_q[l*LANE_W +: LANE_W] <= lane_we_i[l] ?
					wdata_i[l*LANE_W +: LANE_W] :
					mem[addr_i][l*LANE_W +: LANE_W];
			end
		end
	end

	assign rdata_o = rd_q;
endmodule

// file: hw/sbs_core.sv
// Pipelined synchronous burst memory core, 32K words by 36 bits.
// Assumes all pin inputs are synchronous to ref_clk_i except the output
// enable; the pad wires are resolved outside from the enables.

// Function
// - Register address, data, enables, strobes each edge
// - Array of 32768 words, four 9-bit lanes
// - Low lane enable writes only its lane
// - Any lane enable low means write
// - Any lane enable low floats the pins
// - Chip enables sampled only on address loads
// - Processor strobe ignored while main enable high
// - Processor strobe aborts burst, reads new address
// - Processor strobe, aux inactive: power-down, float
// - Controller strobe loads address, accesses or deselects
// - Controller strobe with lane enables low writes
// - Processor start reads; write on next edge
// - Low step advances burst counter when continuing
// - High step holds address, giving wait state
// - Two low bits count linearly and wrap
// - Written data passes to output next cycle
// - Output enable, a valid read and no sampled lane enable gate read drivers
// - Parity off disables parity lines
// - Pins float from power-up until access
// - Writes self-timed once controls are registered
module sbs_core (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic [sbs_pkg::ADDR_W-1:0] word_address_inputs_i,
	input wire logic lane1_write_n_i,
	input wire logic lane2_write_n_i,
	input wire logic lane3_write_n_i,
	input wire logic lane4_write_n_i,
	input wire logic chip_sel_n_i,
	input wire logic aux_select_n_i,
	input wire logic aux_select_i,
	input wire logic proc_addr_strobe_n_i,
	input wire logic ctrl_addr_strobe_n_i,
	input wire logic burst_step_n_i,
	input wire logic out_en_n_i,
	input wire logic parity_off_i,
	input wire logic [sbs_pkg::DATA_W-1:0] data_lines_i,
	input wire logic [sbs_pkg::LANES-1:0] parity_lines_i,
	output logic [sbs_pkg::DATA_W-1:0] data_lines_o,
	output logic data_lines_oe_o,
	output logic [sbs_pkg::LANES-1:0] parity_lines_o,
	output logic parity_lines_oe_o,
	output logic power_down_o
);
	import sbs_pkg::*;

	// ---------------------------------------------------------------
	// Input registers
	// ---------------------------------------------------------------
	logic [ADDR_W-1:0] addr_q;
	logic [LANES-1:0] lane_n_q;
	logic chip_n_q;
	logic aux_n_q;
	logic aux_q;
	logic proc_n_q;
	logic ctrl_n_q;
	logic step_n_q;
	logic [DATA_W-1:0] data_q;
	logic [LANES-1:0] par_q;

	// Decode and pipeline state
	logic proc_go;
	logic ctrl_go;
	logic load;
	logic enables_ok;
	logic wr_any;
	logic access;
	logic step_go;
	logic [LANES-1:0] lane_we;
	logic [ADDR_W-1:0] cur_addr;
	logic [ADDR_W-1:0] acc_addr;
	logic [WORD_W-1:0] wr_word;
	logic [WORD_W-1:0] rd_word;
	logic valid_q;
	sbs_mode_type mode_q;
	sbs_mode_type mode_d;
	logic drive;

	// Every synchronous pin is captured; the decode works from these
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			addr_q <= ADDR_RESET;
			lane_n_q <= LANES_IDLE;
			chip_n_q <= 1'b1;
			aux_n_q <= 1'b1;
			aux_q <= 1'b0;
			proc_n_q <= 1'b1;
			ctrl_n_q <= 1'b1;
			step_n_q <= 1'b1;
			data_q <= DATA_RESET;
			par_q <= LANES_NONE;
		end else if (clk_en_i) begin
			addr_q <= word_address_inputs_i;
			lane_n_q <= {lane4_write_n_i, lane3_write_n_i,
				lane2_write_n_i, lane1_write_n_i};
			chip_n_q <= chip_sel_n_i;
			aux_n_q <= aux_select_n_i;
			aux_q <= aux_select_i;
			proc_n_q <= proc_addr_strobe_n_i;
			ctrl_n_q <= ctrl_addr_strobe_n_i;
			step_n_q <= burst_step_n_i;
			data_q <= data_lines_i;
			par_q <= parity_lines_i;
		end
	end

	// ---------------------------------------------------------------
	// Cycle decode
	// ---------------------------------------------------------------
	// The processor strobe counts only with the main enable low, and
	// it wins over the controller strobe on the same edge
	assign proc_go = !proc_n_q && !chip_n_q;
	assign ctrl_go = !proc_go && !ctrl_n_q;
	assign load = proc_go || ctrl_go;
	// Chip enables matter only on a load; a burst ignores them
	assign enables_ok = !chip_n_q && !aux_n_q && aux_q;
	assign wr_any = !(&lane_n_q);
	// Continuation runs only while selected
	assign access = load ? enables_ok : (mode_q == MODE_ACTIVE);
	assign step_go = !load && !step_n_q && (mode_q == MODE_ACTIVE);

	// A processor start is always a read; its write comes one edge
	// later as a held continuation with the step input high
	always_comb begin
		lane_we = LANES_NONE;
		if (access && wr_any && !proc_go) begin
			lane_we = ~lane_n_q;
		end
	end

	// Selection state follows each load; bursts leave it alone
	always_comb begin
		case (mode_q)
			MODE_DOWN: mode_d = (load && enables_ok) ?
				MODE_ACTIVE : MODE_DOWN;
			MODE_ACTIVE: mode_d = (load && !enables_ok) ?
				MODE_DOWN : MODE_ACTIVE;
			default: mode_d = MODE_DOWN;
		endcase
	end

	// Selection register; reset starts deselected
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			mode_q <= MODE_DOWN;
		end else if (clk_en_i) begin
			mode_q <= mode_d;
		end
	end

	assign power_down_o = (mode_q == MODE_DOWN);

	// ---------------------------------------------------------------
	// Address and array
	// ---------------------------------------------------------------
	// A load replaces any burst in progress at once
	sbs_burst_ctr u_ctr (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.load_i(load),
		.step_i(step_go),
		.load_addr_i(addr_q),
		.cur_addr_o(cur_addr),
		.acc_addr_o(acc_addr)
	);

	// Lane packing: each lane holds its byte with parity on top
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		assign wr_word[g*LANE_W +: BYTE_W] = data_q[g*BYTE_W +: BYTE_W];
		assign wr_word[g*LANE_W + BYTE_W] = par_q[g];
		assign data_lines_o[g*BYTE_W +: BYTE_W] =
			rd_word[g*LANE_W +: BYTE_W];
		assign parity_lines_o[g] = rd_word[g*LANE_W + BYTE_W];
	end

	// The write completes on the edge after capture with no strobe
	// from outside; the array cell is the only timing involved
	sbs_word_mem u_mem (
		.ref_clk_i(ref_clk_i),
		.clk_en_i(clk_en_i),
		.rd_en_i(access),
		.addr_i(acc_addr),
		.lane_we_i(lane_we),
		.wdata_i(wr_word),
		.rdata_o(rd_word)
	);

	// ---------------------------------------------------------------
	// Output drivers
	// ---------------------------------------------------------------
	// Output register holds data only for the cycle after an access;
	// a cycle without an access drops it, so nothing carries over
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			valid_q <= 1'b0;
		end else if (clk_en_i) begin
			valid_q <= access;
		end
	end

	// Output enable is asynchronous; a sampled low lane enable wins
	// over it so that incoming write data never meets our drivers
	assign drive = valid_q && !out_en_n_i && !wr_any;
	assign data_lines_oe_o = drive;
	assign parity_lines_oe_o = drive && !parity_off_i;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	logic any_lane_in;
	logic enables_in;
	assign any_lane_in = !(lane1_write_n_i && lane2_write_n_i &&
		lane3_write_n_i && lane4_write_n_i);
	assign enables_in = !chip_sel_n_i && !aux_select_n_i && aux_select_i;

	sequence seq_proc_in;
		clk_en_i && !proc_addr_strobe_n_i && enables_in;
	endsequence

	sequence seq_write_in;
		clk_en_i && proc_addr_strobe_n_i && ctrl_addr_strobe_n_i &&
			burst_step_n_i && any_lane_in;
	endsequence

	sequence seq_ctrl_write_in;
		clk_en_i && proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i &&
			enables_in && any_lane_in;
	endsequence

	a_lane_float: assert property (
		clk_en_i && any_lane_in |=> !data_lines_oe_o && !parity_lines_oe_o)
		else $error("pins driven after a lane enable sampled low");

	a_oe_gates: assert property (
		out_en_n_i |-> !data_lines_oe_o)
		else $error("data driven while output enable high");

	a_parity_gate: assert property (
		parity_off_i ? !parity_lines_oe_o :
			(parity_lines_oe_o == data_lines_oe_o))
		else $error("parity drivers disagree with parity off");

	a_reset_float: assert property (
		@(posedge ref_clk_i) disable iff (1'b0)
		!reset_n_i |=> !data_lines_oe_o && !parity_lines_oe_o)
		else $error("pins driven after reset");

	a_proc_read: assert property (
		seq_proc_in |=> lane_we == LANES_NONE &&
			acc_addr == $past(word_address_inputs_i))
		else $error("processor start did not read loaded address");

	a_proc_write: assert property (
		seq_proc_in ##1 seq_write_in |=> lane_we != LANES_NONE &&
			acc_addr == $past(word_address_inputs_i, 2))
		else $error("write after processor start missed its address");

	a_ctrl_write: assert property (
		seq_ctrl_write_in |=> lane_we == ~$past({lane4_write_n_i,
			lane3_write_n_i, lane2_write_n_i, lane1_write_n_i}) &&
			acc_addr == $past(word_address_inputs_i))
		else $error("controller write did not reach its lanes");

	a_desel_down: assert property (
		clk_en_i && load && !enables_ok |=> power_down_o && !data_lines_oe_o)
		else $error("deselect did not enter power-down");

	a_burst_wrap: assert property (
		clk_en_i && step_go |=> cur_addr[BURST_W-1:0] ==
			$past(cur_addr[BURST_W-1:0]) + BURST_INC &&
			cur_addr[ADDR_W-1:BURST_W] == $past(cur_addr[ADDR_W-1:BURST_W]))
		else $error("burst step not linear wrap");

	a_wait_hold: assert property (
		clk_en_i && !load && step_n_q |=> $stable(cur_addr))
		else $error("wait state moved the address");

	a_burst_ignores_ce: assert property (
		clk_en_i && proc_addr_strobe_n_i && ctrl_addr_strobe_n_i ##1
			clk_en_i && !power_down_o |=> !power_down_o)
		else $error("burst continuation reacted to chip enables");

	a_proc_ignored: assert property (
		clk_en_i && chip_sel_n_i && ctrl_addr_strobe_n_i ##1 clk_en_i |=>
			$stable(mode_q) && $stable(cur_addr[ADDR_W-1:BURST_W]))
		else $error("processor strobe acted with main enable high");

	a_pass_through: assert property (
		clk_en_i && lane_we == LANES_IDLE |=> valid_q &&
			rd_word == $past(wr_word))
		else $error("written word not in output register");

	a_read_latency: assert property (
		clk_en_i && access ##1 clk_en_i && !access |=> !valid_q)
		else $error("output held beyond its cycle");
endmodule

// file: test/sbs_ctl_model.sv
// Controller model that drives the memory pins from the far side.
// Assumes the bench calls its tasks; pins move 1 ns after a rising edge.
module sbs_ctl_model (
	input wire logic clk_i,
	output logic [sbs_pkg::ADDR_W-1:0] addr_o,
	output logic [3:0] lane_n_o,
	output logic [2:0] sel_o,
	output logic ps_n_o,
	output logic cs_n_o,
	output logic step_n_o,
	output logic oe_n_o,
	output logic drv_o,
	output logic [sbs_pkg::WORD_W-1:0] wd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import sbs_pkg::*;

	logic oe_off;

	// Pins idle at time zero: strobes high, nothing driven
	initial begin
		addr_o = '0;
		lane_n_o = 4'hf;
		sel_o = 3'h1;
		ps_n_o = 1'b1;
		cs_n_o = 1'b1;
		step_n_o = 1'b1;
		oe_n_o = 1'b1;
		drv_o = 1'b0;
		wd_o = '0;
		oe_off = 1'b0;
	end

	// -------------------------------------------
	// One bus cycle, held until the next edge
	// -------------------------------------------
	task automatic cyc(input logic ps, input logic cs, input logic st,
		input logic [3:0] ln, input logic [ADDR_W-1:0] a,
		input logic [WORD_W-1:0] d, input logic [2:0] s);
		@(posedge clk_i);
		#1;
		ps_n_o = ps;
		cs_n_o = cs;
		step_n_o = st;
		lane_n_o = ln;
		addr_o = a;
		sel_o = s;
		drv_o = (ln != 4'hf);
		// Output enable off while we drive, so the pins never fight
		oe_n_o = drv_o | oe_off;
		// Released lines toggle so stale data cannot pass for good
		wd_o = drv_o ? d : ~wd_o;
	endtask

	// Processor-started write; step stays high to keep the loaded address
	task automatic pwrite(input logic [ADDR_W-1:0] a,
		input logic [WORD_W-1:0] d);
		cyc(1'b0, 1'b1, 1'b1, 4'hf, a, d, 3'h1);
		cyc(1'b1, 1'b1, 1'b1, 4'h0, a, d, 3'h1);
	endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench for the burst memory core.
// Assumes the controller model drives every pin but clock enable and parity off; pads resolved here.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import sbs_pkg::*;

	localparam logic [2:0] ON = 3'h1;
	localparam logic [ADDR_W-1:0] A = 15'h0123;
	localparam logic [ADDR_W-1:0] B = 15'h7ffc;
	localparam logic [WORD_W-1:0] D1 = 36'h9_1234_5678;
	localparam logic [WORD_W-1:0] D2 = 36'h6_abcd_ef01;
	localparam logic [WORD_W-1:0] M2 = 36'h2_0000_ff00;

	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic par_off = 1'b0;
	logic clk_en = 1'b1;
	logic [ADDR_W-1:0] addr;
	logic [3:0] ln;
	logic [2:0] sel;
	logic ps_n, cs_n, st_n, oe_n, q_oe, qp_oe, pd;
	logic [WORD_W-1:0] wd;
	logic [DATA_W-1:0] q;
	logic [LANES-1:0] qp;
	int bad_count = 0;
	int n_tests = 0;
	// Pad level: the core wins when it drives, else the controller
	wire logic [DATA_W-1:0] dq = q_oe ? q : wd[31:0];
	wire logic [LANES-1:0] dqp = qp_oe ? qp : wd[35:32];

	always #5 ref_clk = ~ref_clk;

	sbs_core DUT (
		.ref_clk_i(ref_clk),
		.reset_n_i(reset_n),
		.clk_en_i(clk_en),
		.word_address_inputs_i(addr),
		.lane1_write_n_i(ln[0]),
		.lane2_write_n_i(ln[1]),
		.lane3_write_n_i(ln[2]),
		.lane4_write_n_i(ln[3]),
		.chip_sel_n_i(sel[2]),
		.aux_select_n_i(sel[1]),
		.aux_select_i(sel[0]),
		.proc_addr_strobe_n_i(ps_n),
		.ctrl_addr_strobe_n_i(cs_n),
		.burst_step_n_i(st_n),
		.out_en_n_i(oe_n),
		.parity_off_i(par_off),
		.data_lines_i(dq),
		.parity_lines_i(dqp),
		.data_lines_o(q),
		.data_lines_oe_o(q_oe),
		.parity_lines_o(qp),
		.parity_lines_oe_o(qp_oe),
		.power_down_o(pd)
	);

	sbs_ctl_model ctl (
		.clk_i(ref_clk),
		.addr_o(addr),
		.lane_n_o(ln),
		.sel_o(sel),
		.ps_n_o(ps_n),
		.cs_n_o(cs_n),
		.step_n_o(st_n),
		.oe_n_o(oe_n),
		.drv_o(),
		.wd_o(wd)
	);

	// -------------------------------------------
	// Compare and helper tasks
	// -------------------------------------------
	// Settle 1 ns so the async output enable has landed
	task automatic chk_w(input logic [WORD_W-1:0] e);
		#1;
		n_tests++;
		if ({q_oe, qp, q} !== {1'b1, e}) begin
			bad_count++;
			$display("ERROR %0t word %h exp %h", $time, {qp, q}, e);
		end
	endtask

	task automatic chk_f(input logic got, input logic e);
		#1;
		n_tests++;
		if (got !== e) begin
			bad_count++;
			$display("ERROR %0t flag %b exp %b", $time, got, e);
		end
	endtask

	// Suspend cycle: reads the current address again
	task automatic idle;
		ctl.cyc(1'b1, 1'b1, 1'b1, 4'hf, '0, '0, ON);
	endtask

	// Data shows two driven cycles after the load
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e);
		ctl.cyc(1'b0, 1'b1, 1'b1, 4'hf, a, '0, ON);
		idle;
		idle;
		chk_w(e);
	endtask

	function automatic logic [WORD_W-1:0] wv(input logic [1:0] i);
		return 36'h3_5a5a_5a00 + {34'h0, i};
	endfunction

	// -------------------------------------------
	// Scenarios
	// -------------------------------------------
	task automatic t_reset;
		chk_f(q_oe, 1'b0);
		chk_f(pd, 1'b1);
		$display("t_reset done");
	endtask

	task automatic t_write;
		ctl.cyc(1'b1, 1'b0, 1'b1, 4'h0, A, D1, ON);
		idle;
		chk_f(q_oe, 1'b0);
		idle;
		chk_w(D1);
		chk_f(qp_oe, 1'b1);
		rd(A, D1);
		ctl.cyc(1'b1, 1'b0, 1'b1, 4'hd, A, D2, ON);
		rd(A, (D1 & ~M2) | (D2 & M2));
		$display("t_write done");
	endtask

	task automatic t_burst;
		logic [1:0] lo [5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
		for (int i = 0; i < 4; i++) begin
			ctl.cyc(1'b1, 1'b0, 1'b1, 4'h0, B + 15'(i), wv(2'(i)), ON);
		end
		for (int i = 0; i < 7; i++) begin
			if (i == 0) begin
				ctl.cyc(1'b0, 1'b1, 1'b1, 4'hf, B + 15'h1, '0, ON);
			end else begin
				ctl.cyc(1'b1, 1'b1, i == 3 || i > 4, 4'hf, '0, '0, ON);
			end
			if (i > 1) begin
				chk_w(wv(lo[i-2]));
			end
		end
		$display("t_burst done");
	endtask

	// Strobe with the main enable high continues the burst instead
	task automatic t_ignore;
		ctl.cyc(1'b0, 1'b1, 1'b1, 4'hf, B, '0, ON);
		ctl.cyc(1'b0, 1'b1, 1'b0, 4'hf, A, '0, 3'h5);
		idle;
		chk_w(wv(2'h0));
		idle;
		chk_w(wv(2'h1));
		chk_f(pd, 1'b0);
		$display("t_ignore done");
	endtask

	task automatic desel(input logic ps, input logic cs, input logic [2:0] s);
		rd(A, D1 & ~M2 | D2 & M2);
		ctl.cyc(ps, cs, 1'b1, 4'hf, A, '0, s);
		idle;
		idle;
		chk_f(pd, 1'b1);
		chk_f(q_oe, 1'b0);
	endtask

	task automatic t_desel;
		desel(1'b0, 1'b1, 3'h0);
		desel(1'b0, 1'b1, 3'h3);
		desel(1'b1, 1'b0, 3'h5);
		$display("t_desel done");
	endtask

	task automatic t_pwrite;
		ctl.pwrite(A, D2);
		// Both strobes low: the processor start wins and never writes
		ctl.cyc(1'b0, 1'b0, 1'b1, 4'h0, A, D1, ON);
		rd(A, D2);
		$display("t_pwrite done");
	endtask

	task automatic t_oe;
		ctl.oe_off = 1'b1;
		ctl.cyc(1'b0, 1'b1, 1'b1, 4'hf, A, '0, ON);
		idle;
		idle;
		chk_f(q_oe, 1'b0);
		ctl.oe_off = 1'b0;
		par_off = 1'b1;
		rd(A, D2);
		chk_f(qp_oe, 1'b0);
		par_off = 1'b0;
		$display("t_oe done");
	endtask

	// Clock enable low freezes capture, decode and counter alike; the
	// steps carry inactive chip enables, which a burst must not heed
	task automatic t_hold;
		ctl.cyc(1'b0, 1'b1, 1'b1, 4'hf, B, '0, ON);
		ctl.cyc(1'b1, 1'b1, 1'b0, 4'hf, '0, '0, 3'h0);
		clk_en = 1'b0;
		repeat (2) ctl.cyc(1'b1, 1'b1, 1'b0, 4'hf, '0, '0, 3'h0);
		clk_en = 1'b1;
		idle;
		chk_w(wv(2'h0));
		idle;
		chk_w(wv(2'h1));
		chk_f(pd, 1'b0);
		$display("t_hold done");
	endtask

	// -------------------------------------------
	// Verdict, watchdog and main sequence
	// -------------------------------------------
	task automatic summarize;
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Tests need under 200 cycles; a hang stops far beyond that
	initial begin
		#20000;
		bad_count++;
		$display("ERROR %0t watchdog expired", $time);
		summarize;
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		t_reset;
		t_write;
		t_burst;
		t_ignore;
		t_desel;
		t_pwrite;
		t_oe;
		t_hold;
		summarize;
	end
endmodule
